// ---- async_tributary_mapping_source.sv ----
// source adaptation mapping a 34 368 kbit/s bit stream into a vc-3 container

`timescale 1ns/100ps

module async_tributary_mapping_source #(
    parameter int DEPTH       = mapper_pkg::STORE_DEPTH,   // store size in bits, power of two
    parameter int FILL_WINDOW = mapper_pkg::FILL_WINDOW    // half width of the dead band
) (
    input  wire logic       core_clk,              // vc-3 clock
    input  wire logic       rst,                   // synchronous, active high
    input  wire logic       ce,                    // freezes the vc-3 side while low; store writes stop two trib_clk edges later
    input  wire logic       trib_clk,              // clock that comes with the tributary bits
    input  wire logic       trib_data,             // tributary bit, valid on trib_clk
    input  wire logic       container_timing_ck,   // one vc-3 byte slot per high cycle
    input  wire logic       container_timing_fs,   // marks the slot of row 0 column 0
    input  wire logic       activation_control,    // output accessed only while high
    output logic      [7:0] vc3_data,              // vc-3 byte, msb first on the line
    output logic            vc3_valid,             // vc3_data holds a byte this cycle
    output logic            vc3_fs                 // fixed frame start, with row 0 column 0
);
    // thresholds around the middle of the store
    localparam logic [6:0] FILL_LOW  = 7'(DEPTH / 2 - FILL_WINDOW);
    localparam logic [6:0] FILL_HIGH = 7'(DEPTH / 2 + FILL_WINDOW);
    localparam logic [6:0] LAST_COL  = 7'(mapper_pkg::COLS - 1);
    localparam logic [3:0] LAST_ROW  = 4'(mapper_pkg::ROWS - 1);
    localparam logic [1:0] LAST_SUB  = 2'(mapper_pkg::SUB_ROWS - 1);
    localparam logic [3:0] FULL_BYTE = 4'(mapper_pkg::BITS_BYTE);

    // justification outcome for one three-row frame
    typedef enum {
        JUST_NONE,
        JUST_POS,
        JUST_NEG
    } just_t;

    // tributary side housekeeping
    logic       trib_rst_s1_ff;    // reset entering the tributary domain
    logic       trib_rst_ff;       // reset as seen by the write side
    logic       trib_ce_s1_ff;     // enable entering the tributary domain
    logic       trib_ce_ff;        // enable as seen by the write side

    // frame position
    logic [6:0] col_ff;            // next byte's column, 0 is overhead
    logic [3:0] row_ff;            // next byte's row
    logic [1:0] sub_ff;            // row within the justification frame
    logic [6:0] cur_col;           // column of the byte being built
    logic [3:0] cur_row;           // row of the byte being built
    logic [1:0] cur_sub;           // justification row of the byte being built

    // justification state
    just_t      just_ff;           // decision in force for this frame
    just_t      nxt_just;          // decision taken from the fill level
    logic       s1_data;           // S1 carries a tributary bit
    logic       s2_data;           // S2 carries a tributary bit

    // store interface
    logic [7:0] peek;              // next eight stored bits, oldest first
    logic [6:0] fill;              // bits waiting in the store
    logic [3:0] rd_adv;            // bits used by this slot
    logic [7:0] nxt_byte;          // byte built for this slot

    // output registers
    logic [7:0] data_ff;
    logic       valid_ff;
    logic       fs_ff;

    // slot strobe, the position counters, the decision and the store reads move on it
    logic       slot;
    assign slot = ce && container_timing_ck;

    // reset and enable reach the write side through two stages each
    always_ff @(posedge trib_clk) begin
        trib_rst_s1_ff <= rst;
        trib_rst_ff    <= trib_rst_s1_ff;
    end

    // enable crossing; a frozen write side simply stops storing bits
    always_ff @(posedge trib_clk) begin
        trib_ce_s1_ff <= ce;
        trib_ce_ff    <= trib_ce_s1_ff;
    end

    // the store; 64 bits covers +-20 ppm many times over, since the
    // dead band only moves by one bit per three rows and the rate
    // offset is a fraction of a bit per row
    elastic_store #(
        .DEPTH (DEPTH)
    ) u_store (
        .trib_clk  (trib_clk),
        .trib_rst  (trib_rst_ff),
        .trib_ce   (trib_ce_ff && !trib_rst_ff),
        .trib_data (trib_data),
        .core_clk  (core_clk),
        .rst       (rst),
        // the pointer crossing runs every enabled cycle so the fill seen at the
        // decision slot is fresh; reads still advance only on a taken slot
        .ce        (ce),
        .rd_adv    (slot ? rd_adv : 4'h0),
        .rd_peek   (peek),
        .fill      (fill)
    );

    // a frame start pulls the position back to the top corner
    always_comb begin
        if (container_timing_fs) begin
            cur_col = 7'h00;
            cur_row = 4'h0;
            cur_sub = 2'h0;
        end else begin
            cur_col = col_ff;
            cur_row = row_ff;
            cur_sub = sub_ff;
        end
    end

    // column, row and justification row counters
    always_ff @(posedge core_clk) begin
        if (rst) begin
            col_ff <= 7'h00;
            row_ff <= 4'h0;
            sub_ff <= 2'h0;
        end else if (slot) begin
            if (cur_col == LAST_COL) begin
                // end of row: move down, wrap at the frame bottom
                col_ff <= 7'h00;
                row_ff <= (cur_row == LAST_ROW) ? 4'h0 : cur_row + 4'h1;
                sub_ff <= (cur_sub == LAST_SUB || cur_row == LAST_ROW) ? 2'h0
                                                                       : cur_sub + 2'h1;
            end else begin
                col_ff <= cur_col + 7'h01;
                row_ff <= cur_row;
                sub_ff <= cur_sub;
            end
        end
    end

    // fill level picks the action: low fill means the tributary is slow,
    // so hold a bit back; high fill means it is fast, so take one extra
    always_comb begin
        if (fill < FILL_LOW) begin
            nxt_just = JUST_POS;
        end else if (fill > FILL_HIGH) begin
            nxt_just = JUST_NEG;
        end else begin
            nxt_just = JUST_NONE;
        end
    end

    // the decision is latched on the overhead byte that opens each
    // justification frame, ahead of the control and opportunity bits
    always_ff @(posedge core_clk) begin
        if (rst) begin
            just_ff <= JUST_NONE;
        end else if (slot && cur_col == 7'h00 && cur_sub == 2'h0) begin
            just_ff <= nxt_just;
        end
    end

    // map the decision onto the two opportunity bits
    always_comb begin
        case (just_ff)
            JUST_POS: begin
                s1_data = 1'b0;    // neither opportunity bit carries data
                s2_data = 1'b0;
            end
            JUST_NEG: begin
                s1_data = 1'b1;    // extra bit goes into S1
                s2_data = 1'b1;    // and S2 carries data too
            end
            JUST_NONE: begin
                s1_data = 1'b0;    // S2 alone carries data
                s2_data = 1'b1;
            end
            default: begin
                s1_data = 1'b0;
                s2_data = 1'b1;
            end
        endcase
    end

    // build one byte for the current slot and count the bits it uses
    always_comb begin
        logic [6:0] pos;           // byte offset inside the container row
        logic [4:0] grp;           // four-byte group index
        logic [1:0] lane;          // byte within the group
        pos      = 7'h00;
        grp      = 5'h00;
        lane     = 2'h0;
        nxt_byte = mapper_pkg::OTHER_POH;
        rd_adv   = 4'h0;
        if (cur_col == 7'h00) begin
            // overhead column: only the payload specific bytes are ours
            if (cur_row == mapper_pkg::LABEL_ROW) begin
                nxt_byte = mapper_pkg::SIGNAL_LABEL;
            end else if (cur_row == mapper_pkg::SPARE_ROW) begin
                nxt_byte = mapper_pkg::SPARE_VALUE;
            end
        end else begin
            pos  = cur_col - 7'h01;
            grp  = pos[6:2];
            lane = pos[1:0];
            if (lane != 2'h0) begin
                // data byte of a group
                if (cur_sub == 2'h2 && grp == 5'h00 && lane == 2'h1) begin
                    // S2 leads this byte, seven data bits follow
                    if (s2_data) begin
                        nxt_byte = peek;
                        rd_adv   = FULL_BYTE;
                    end else begin
                        nxt_byte = {1'b0, peek[7:1]};
                        rd_adv   = FULL_BYTE - 4'h1;
                    end
                end else begin
                    nxt_byte = peek;
                    rd_adv   = FULL_BYTE;
                end
            end else if (cur_sub != 2'h2 && grp == 5'h00) begin
                // stuff byte ending in the control bits; zero means data follows.
                // three copies per frame let the far end take a majority
                nxt_byte = {mapper_pkg::STUFF_VALUE[7:2], !s1_data, !s2_data};
            end else if (cur_sub == 2'h0 && grp == 5'h01) begin
                // third copy of the control bits
                nxt_byte = {mapper_pkg::STUFF_VALUE[7:2], !s1_data, !s2_data};
            end else if (cur_sub == 2'h2 && grp == 5'h00) begin
                // stuff byte ending in S1
                nxt_byte = {mapper_pkg::STUFF_VALUE[7:1], s1_data && peek[7]};
                rd_adv   = {3'h0, s1_data};
            end else begin
                nxt_byte = mapper_pkg::STUFF_VALUE;
            end
        end
    end

    // output byte and strobe; nothing is driven while not activated
    always_ff @(posedge core_clk) begin
        if (rst) begin
            data_ff  <= 8'h00;
            valid_ff <= 1'b0;
        end else if (ce) begin
            if (container_timing_ck && activation_control) begin
                data_ff  <= nxt_byte;
                valid_ff <= 1'b1;
            end else begin
                data_ff  <= 8'h00;
                valid_ff <= 1'b0;
            end
        end
    end

    // fixed frame start: always with the top corner byte
    always_ff @(posedge core_clk) begin
        if (rst) begin
            fs_ff <= 1'b0;
        end else if (ce) begin
            fs_ff <= container_timing_ck && activation_control
                     && cur_col == 7'h00 && cur_row == 4'h0;
        end
    end

    // outputs straight from their registers
    assign vc3_data  = data_ff;
    assign vc3_valid = valid_ff;
    assign vc3_fs    = fs_ff;
endmodule

// ---- elastic_store.sv ----
// package of shared constants and the bit-wide elastic store between tributary and vc-3 clocks
package mapper_pkg;
    // vc-3 frame geometry: one path overhead column plus the 84-byte container-3 row
    localparam int       ROWS         = 9;
    localparam int       COLS         = 85;
    localparam int       GROUP_BYTES  = 4;     // R byte followed by three data bytes
    localparam int       SUB_ROWS     = 3;     // rows that make one justification frame
    localparam int       BITS_BYTE    = 8;
    // path overhead rows carrying the payload specific bytes
    localparam logic [3:0] LABEL_ROW  = 4'h2;
    localparam logic [3:0] SPARE_ROW  = 4'h5;
    // fixed values placed on the line
    localparam logic [7:0] SIGNAL_LABEL = 8'h04;  // asynchronous 34 368 kbit/s into container-3
    localparam logic [7:0] SPARE_VALUE  = 8'h00;  // content of the spare overhead byte
    localparam logic [7:0] STUFF_VALUE  = 8'h00;  // content of fixed stuff bits
    localparam logic [7:0] OTHER_POH    = 8'h00;  // overhead bytes owned by path termination
    // tributary rate and tolerance that size the store
    localparam int       TRIB_RATE_KBPS = 34368;
    localparam int       TRIB_TOL_PPM   = 20;
    // store size and the window around its middle where no justification is made
    localparam int       STORE_DEPTH    = 64;
    localparam int       FILL_WINDOW    = 8;

    // binary to gray for the pointer crossing
    function automatic logic [6:0] bin2gray(input logic [6:0] b);
        return b ^ (b >> 1);
    endfunction

    // gray back to binary on the reading side
    function automatic logic [6:0] gray2bin(input logic [6:0] g);
        logic [6:0] b;
        b = g;
        for (int i = 5; i >= 0; i--) begin
            b[i] = b[i + 1] ^ g[i];
        end
        return b;
    endfunction
endpackage

`timescale 1ns/100ps

module elastic_store #(
    parameter int DEPTH = mapper_pkg::STORE_DEPTH
) (
    input  wire logic       trib_clk,
    input  wire logic       trib_rst,
    input  wire logic       trib_ce,
    input  wire logic       trib_data,
    input  wire logic       core_clk,
    input  wire logic       rst,
    input  wire logic       ce,
    input  wire logic [3:0] rd_adv,
    output logic      [7:0] rd_peek,
    output logic      [6:0] fill
);
    localparam int AW = $clog2(DEPTH);

    logic       mem [DEPTH];     // one tributary bit per entry
    logic [6:0] wr_bin_ff;       // write pointer, tributary domain
    logic [6:0] wr_gray_ff;      // gray copy that crosses
    logic [6:0] gray_s1_ff;      // first synchroniser stage
    logic [6:0] gray_s2_ff;      // second synchroniser stage
    logic [6:0] rd_ptr_ff;       // read pointer, vc-3 domain
    logic [6:0] nxt_wr_bin;

    assign nxt_wr_bin = wr_bin_ff + 7'h01;

    // bits land in the store on the clock that came with them
    always_ff @(posedge trib_clk) begin
        if (trib_ce) begin
            mem[wr_bin_ff[AW-1:0]] <= trib_data;
        end
    end

    // write pointer and its gray image move together
    always_ff @(posedge trib_clk) begin
        if (trib_rst) begin
            wr_bin_ff  <= 7'h00;
            wr_gray_ff <= 7'h00;
        end else if (trib_ce) begin
            wr_bin_ff  <= nxt_wr_bin;
            wr_gray_ff <= mapper_pkg::bin2gray(nxt_wr_bin);
        end
    end

    // only one pointer bit changes per write, so two stages are safe
    always_ff @(posedge core_clk) begin
        if (rst) begin
            gray_s1_ff <= 7'h00;
            gray_s2_ff <= 7'h00;
        end else if (ce) begin
            gray_s1_ff <= wr_gray_ff;
            gray_s2_ff <= gray_s1_ff;
        end
    end

    // read pointer steps by the bits the framer used this byte
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rd_ptr_ff <= 7'h00;
        end else if (ce) begin
            rd_ptr_ff <= rd_ptr_ff + {3'h0, rd_adv};
        end
    end

    // fill level seen from the vc-3 side, a little late but never early
    assign fill = mapper_pkg::gray2bin(gray_s2_ff) - rd_ptr_ff;

    // next eight bits, oldest in the msb
    always_comb begin
        rd_peek = 8'h00;
        for (int i = 0; i < 8; i++) begin
            rd_peek[7 - i] = mem[AW'(rd_ptr_ff[AW-1:0] + AW'(i))];
        end
    end
endmodule

// ---- mapper_checker.sv ----
// checker: timing and content of the mapper's vc-3 output
`timescale 1ns/100ps
module mapper_checker #(
    parameter int DEPTH       = 64,
    parameter int FILL_WINDOW = 8
) (
    input wire logic       core_clk,
    input wire logic       rst,
    input wire logic       ce,
    input wire logic       trib_clk,
    input wire logic       trib_data,
    input wire logic       container_timing_ck,
    input wire logic       container_timing_fs,
    input wire logic       activation_control,
    input wire logic [7:0] vc3_data,
    input wire logic       vc3_valid,
    input wire logic       vc3_fs
);
    logic [9:0] pos_ff;   // frame slot that the next slot takes
    logic [9:0] opos_ff;  // frame slot of the byte now on the output
    logic [2:0] ctl_ff;   // copy valid flag, then c1 c2
    logic [9:0] cur;      // frame slot of a slot offered now
    logic       first;    // first control copy of a justification frame
    logic       copy;     // later control copies

    // fs forces slot 0 so the count follows the timing source
    assign cur   = container_timing_fs ? 10'h000 : pos_ff;
    assign first = opos_ff == 10'h001 || opos_ff == 10'h100 || opos_ff == 10'h1FF;
    assign copy  = opos_ff == 10'h005 || opos_ff == 10'h056 || opos_ff == 10'h104
                || opos_ff == 10'h155 || opos_ff == 10'h203 || opos_ff == 10'h254;

    // position follows every taken slot, active or not, as the store does
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pos_ff  <= 10'h000;
            opos_ff <= 10'h000;
        end else if (ce && container_timing_ck) begin
            pos_ff  <= (cur == 10'h2FC) ? 10'h000 : cur + 10'h001;
            opos_ff <= cur;
        end
    end

    // an inactive slot voids the copy, so a stale value is never compared
    always_ff @(posedge core_clk) begin
        if (rst) begin
            ctl_ff <= 3'h0;
        end else if (ce && container_timing_ck && !activation_control) begin
            ctl_ff <= 3'h0;
        end else if (vc3_valid && first) begin
            ctl_ff <= {1'b1, vc3_data[1:0]};
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence s_take;
        ce && container_timing_ck && activation_control;
    endsequence
    sequence s_frame;
        s_take ##0 container_timing_fs;
    endsequence

    a_slot_answer: assert property (s_take |=> vc3_valid)
        else $error("no byte after an active slot");
    a_no_stray: assert property (!(ce && container_timing_ck && activation_control)
        |=> !vc3_valid)
        else $error("byte without an active slot");
    a_fs_frame: assert property (s_frame |=> vc3_fs && vc3_valid)
        else $error("frame start missing");
    a_fs_cause: assert property (vc3_fs |-> $past(container_timing_fs && activation_control))
        else $error("frame start off its slot");
    a_idle_zero: assert property (!vc3_valid |-> vc3_data == 8'h00)
        else $error("output driven while idle");
    a_label_byte: assert property (vc3_valid && opos_ff == 10'h0AA
        |-> vc3_data == mapper_pkg::SIGNAL_LABEL)
        else $error("wrong signal label");
    a_ctl_copies: assert property (vc3_valid && copy && ctl_ff[2]
        |-> vc3_data[1:0] == ctl_ff[1:0])
        else $error("control copies disagree");
    a_ctl_code: assert property (vc3_valid && first |-> vc3_data[1:0] != 2'h1)
        else $error("control code outside the chosen set");
endmodule

bind async_tributary_mapping_source mapper_checker #(
    .DEPTH(DEPTH), .FILL_WINDOW(FILL_WINDOW)
) u_mapper_checker (
    .core_clk(core_clk), .rst(rst), .ce(ce), .trib_clk(trib_clk), .trib_data(trib_data),
    .container_timing_ck(container_timing_ck), .container_timing_fs(container_timing_fs),
    .activation_control(activation_control), .vc3_data(vc3_data),
    .vc3_valid(vc3_valid), .vc3_fs(vc3_fs)
);

// ---- tb.sv ----
// testbench: prbs tributary through the mapper into the path model
`timescale 1ns/100ps
module tb;
    logic        core_clk  = 1'b0;
    logic        rst       = 1'b1;
    logic        trib_clk  = 1'b0;
    logic        trib_data = 1'b0;
    logic        act       = 1'b1;
    logic        run       = 1'b0;
    logic        slot_ck;
    logic        slot_fs;
    logic        vc3_valid;
    logic        vc3_fs;
    logic [7:0]  vc3_data;
    logic [15:0] n_pos;
    logic [15:0] n_neg;
    logic [15:0] n_none;
    logic [15:0] n_bad;
    logic [14:0] prbs      = 15'h7FFF;
    int          gap       = 0;
    int          n_fail    = 0;
    int          tests_run = 0;

    always #2 core_clk = ~core_clk;

    // gapped once in 85 periods so the bit rate equals the nominal payload rate
    initial #1.3 forever begin
        #6 trib_clk = (gap != 84);
        gap = (gap == 84) ? 0 : gap + 1;
        #6 trib_clk = 1'b0;
    end

    // prbs source: a dropped or repeated bit shows at the decoder
    always @(posedge trib_clk) begin
        prbs      <= {prbs[13:0], prbs[14] ^ prbs[13]};
        trib_data <= prbs[14] ^ prbs[13];
    end

    async_tributary_mapping_source dut (
        .core_clk(core_clk), .rst(rst), .ce(1'b1), .trib_clk(trib_clk), .trib_data(trib_data),
        .container_timing_ck(slot_ck), .container_timing_fs(slot_fs),
        .activation_control(act), .vc3_data(vc3_data), .vc3_valid(vc3_valid), .vc3_fs(vc3_fs)
    );
    vc3_path_model path (
        .core_clk(core_clk), .run(run), .act(act), .vc3_data(vc3_data),
        .vc3_valid(vc3_valid), .vc3_fs(vc3_fs), .slot_ck(slot_ck), .slot_fs(slot_fs),
        .n_pos(n_pos), .n_neg(n_neg), .n_none(n_none), .n_bad(n_bad)
    );

    task automatic check(input logic ok, input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (ok !== 1'b1) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // reset, then let pre bits gather in the store before the first slot
    task automatic restart(input int pre);
        run <= 1'b0;
        rst <= 1'b1;
        repeat (12) @(posedge core_clk);
        rst <= 1'b0;
        repeat (pre * 3) @(posedge core_clk);
        run <= 1'b1;
    endtask

    // bounded wait for n decoded justification frames
    task automatic wait_jf(input int n);
        int k;
        k = 0;
        while (n_pos + n_neg + n_none < n && k < 30000) begin
            @(posedge core_clk);
            #1;
            k++;
        end
    endtask

    // preload below, inside or above the dead band picks the justification kind
    task automatic t_justify(input int pre, input int kind);
        logic [15:0] cnt;
        restart(pre);
        wait_jf(3);
        cnt = (kind == 0) ? n_pos : (kind == 1) ? n_none : n_neg;
        check(cnt === 16'h0003, cnt, 16'h0003);
        check(n_bad === 16'h0000, n_bad, 16'h0000);
        $display("justify test %0d done", kind);
    endtask

    // muted output keeps its frame position; payload resumes without a slip
    task automatic t_activation();
        logic [15:0] seen;
        restart(32);
        repeat (3000) @(posedge core_clk);
        act <= 1'b0;
        repeat (3000) @(posedge core_clk);
        act <= 1'b1;
        #1;
        seen = n_pos + n_neg + n_none;
        wait_jf(seen + 4);
        check(n_none === seen + 16'h0004, n_none, seen + 16'h0004);
        check(n_bad === 16'h0000, n_bad, 16'h0000);
        $display("activation test done");
    endtask

    task automatic conclude();
        $display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        t_justify(12, 0);
        t_justify(32, 1);
        t_justify(48, 2);
        t_activation();
        conclude();
    end

    // about 68k cycles are expected; this cuts a hang short
    initial begin
        #400000;
        n_fail++;
        conclude();
    end
endmodule

// ---- vc3_path_model.sv ----
// vc-3 path side model: slot timing source and prbs payload decoder
`timescale 1ns/100ps
module vc3_path_model (
    input  wire logic        core_clk,
    input  wire logic        run,        // low: no slots, counts cleared
    input  wire logic        act,        // low: decoder drops its lock
    input  wire logic [7:0]  vc3_data,
    input  wire logic        vc3_valid,
    input  wire logic        vc3_fs,
    output logic             slot_ck,    // one byte slot every SLOT cycles
    output logic             slot_fs,    // first slot of a frame
    output logic      [15:0] n_pos,      // justification frames seen, by kind
    output logic      [15:0] n_neg,
    output logic      [15:0] n_none,
    output logic      [15:0] n_bad       // prbs slips, label and control faults
);
    localparam int SLOT = 18;  // six tributary bits per slot at the bench rates
    int          div = 0;      // cycle within slot
    int          pos = 0;      // slot within frame
    int          col;
    int          row;
    int          nb;           // bits since lock, prediction needs 15
    logic        lock;
    logic        m1;           // majority of c1 copies
    logic        m2;
    logic [2:0]  v1;
    logic [2:0]  v2;
    logic [14:0] sh;           // newest decoded bit in sh[0]

    initial begin
        slot_ck = 1'b0;
        slot_fs = 1'b0;
    end

    // slot strobe; restarting the run restarts the frame
    always @(posedge core_clk) begin
        slot_ck <= run && div == 0;
        slot_fs <= run && div == 0 && pos == 0;
        if (!run) begin
            div = 0;
            pos = 0;
        end else begin
            div = (div == SLOT - 1) ? 0 : div + 1;
            if (div == 0) pos = (pos == 764) ? 0 : pos + 1;
        end
    end

    // self-synchronising check: each bit follows from the 15 before it
    task automatic take(input logic b);
        if (nb >= 15 && b !== (sh[14] ^ sh[13])) n_bad = n_bad + 1;
        sh = {sh[13:0], b};
        nb = nb + 1;
    endtask

    // one byte of the frame; stuff bytes and other overhead are ignored
    task automatic decode(input logic [7:0] d);
        int k;
        int ph;
        k = (col - 1) % 4;
        ph = row % 3;
        if (col == 0) begin
            if (row == 2 && d !== mapper_pkg::SIGNAL_LABEL) n_bad = n_bad + 1;
        end else if (col == 1 && ph < 2 || col == 5 && ph == 0) begin
            v1 = {v1[1:0], d[1]};
            v2 = {v2[1:0], d[0]};
        end else if (col == 1) begin
            m1 = v1[2] & v1[1] | v1[1] & v1[0] | v1[2] & v1[0];
            m2 = v2[2] & v2[1] | v2[1] & v2[0] | v2[2] & v2[0];
            if (v1 !== {3{m1}} || v2 !== {3{m2}}) n_bad = n_bad + 1;
            if (!m1) take(d[0]);
            if (m1 && m2) n_pos = n_pos + 1;
            else if (!m1 && !m2) n_neg = n_neg + 1;
            else n_none = n_none + 1;
        end else if (col == 2 && ph == 2) begin
            if (!m2) take(d[7]);
            for (int i = 6; i >= 0; i--) take(d[i]);
        end else if (k != 0) begin
            for (int i = 7; i >= 0; i--) take(d[i]);
        end
        col = (col == 84) ? 0 : col + 1;
        if (col == 0) row = (row == 8) ? 0 : row + 1;
    endtask

    // lock on the frame start, lose it whenever the output is muted
    always @(posedge core_clk) begin
        if (!run) begin
            {n_pos, n_neg, n_none, n_bad} = '0;
            lock = 1'b0;
        end else if (vc3_valid && act) begin
            if (vc3_fs) begin
                lock = 1'b1;
                col = 0;
                row = 0;
                nb = 0;
            end
            if (lock) decode(vc3_data);
        end
        if (!act) lock = 1'b0;
    end
endmodule
